// ==== tape_engine_model.sv ====
// Purpose: Behavioural tape engine on the controller's far side
// Assumes: Started by a one-cycle pulse, answers with a one-cycle done
// Notes: Read fills the buffer with record index plus offset; bus inverted when idle
`timescale 1ns/1ps
module tape_engine_model
  import tape_pkt_pkg::*;
(
  input wire logic  sys_clk,
  input tapeReq_s   tapeReq,
  input wire logic  tapeStart,
  output logic      tapeDone,
  output logic [7:0] tapeResult,
  output logic [6:0] tapeBufAddr,
  output logic      tapeBufWe,
  output logic [7:0] tapeBufWdata
);
  initial {tapeDone, tapeResult, tapeBufAddr, tapeBufWe, tapeBufWdata} = '0;
  // Serve one op at a time; done never in the start cycle
  always begin
    @(posedge sys_clk);
    if (tapeStart === 1'b1) begin
      for (int i = 0; i < 128; i++) begin
        tapeBufWe    <= (tapeReq.op == TOP_READ);
        tapeBufAddr  <= i[6:0];
        tapeBufWdata <= tapeReq.record[7:0] + i[7:0];
        @(posedge sys_clk);
      end
      tapeBufWe    <= 1'b0;
      tapeBufWdata <= ~tapeBufWdata;
      tapeDone     <= 1'b1;
      tapeResult   <= RES_OK;
      @(posedge sys_clk);
      tapeDone     <= 1'b0;
      tapeResult   <= ~tapeResult;
    end
  end
endmodule : tape_engine_model

// ==== tape_packet_command_controller.sv ====
// Purpose: Packet command interpreter between a host byte link and a tape engine
// Assumes: Link bytes and tape engine share sys_clk; cartridge pins are asynchronous
// Notes: Registers sit on an Avalon-MM slave with one wait state per access
`timescale 1ns/1ps
module tape_packet_command_controller
  import tape_pkt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  output tapeReq_s         tapeReq,
  output logic             tapeStart,
  input  wire logic        tapeDone,
  input  wire logic [7:0]  tapeResult,
  input  wire logic [6:0]  tapeBufAddr,
  input  wire logic        tapeBufWe,
  input  wire logic [7:0]  tapeBufWdata,
  output logic [7:0]       tapeBufRdata,
  input  wire logic [1:0]  cartPresent,
  input  wire logic [1:0]  writeProtect
);
  state_e      state_r;
  logic [7:0]  scratch_r [SCRATCH_BYTES];
  logic [7:0]  buf_r     [BUF_BYTES];
  logic [7:0]  rxIdx_r, dataN_r, result_r, txData_r, txIdx_r, bufRd_r;
  logic [15:0] rxCk_r, txCk_r, remain_r, xfer_r;
  logic [10:0] record_r;
  logic [7:0]  diagCnt_r;
  logic        diagFail_r, ckLoOk_r, txStart_r, txBusy_r, txValid_r, xoff_r;
  logic        tapeStart_r, tapeGo_r;
  tapeOp_e     tapeOp_r;
  pktKind_e    txKind_r;
  tapeReq_s    tapeReq_r;
  logic [1:0]  cartMeta_r, cartSync_r, wpMeta_r, wpSync_r;
  logic [31:0] ctrl_r, rdData_r;
  logic        ack_r;
  logic [7:0]  opc, modf, unit, swb, txByte, txLen, bufIdx, rxOff, dataEnd;
  logic [15:0] cnt, blk, maxBlk;
  logic [10:0] recNext, recFirst;
  logic        rxTake, txWait, special, cmdCkOk;

  // Command fields live in the scratch half of the RAM
  assign opc      = scratch_r[CB_OP];
  assign modf     = scratch_r[CB_MOD];
  assign unit     = scratch_r[CB_UNIT];
  assign swb      = scratch_r[CB_SW];
  assign cnt      = {scratch_r[CB_CNT+1], scratch_r[CB_CNT]};
  assign blk      = {scratch_r[CB_BLK+1], scratch_r[CB_BLK]};
  assign cmdCkOk  = {scratch_r[CB_CK+1], scratch_r[CB_CK]} == rxCk_r;
  assign special  = modf[MOD_SPECIAL_BIT];
  assign maxBlk   = special ? MAX_BLK_SPEC : MAX_BLK_NORM;
  // Normal 512-byte blocks are four 128-byte records each
  assign recFirst = special ? blk[10:0] : {blk[8:0], 2'b00};
  assign recNext  = record_r + 11'h001;
  assign dataEnd  = dataN_r + 8'h02;
  assign rxOff    = rxIdx_r - 8'h02;
  assign bufIdx   = txIdx_r - 8'h02;

  // Host bytes taken only in states that consume them; elsewhere a byte would be lost
  assign rxReady = ctrl_r[0] && (state_r == S_IDLE || state_r == S_CMD ||
                                 state_r == S_WR_RX || state_r == S_RD_TX);
  assign rxTake  = rxValid && rxReady;
  assign txWait  = txStart_r || txBusy_r;
  assign txData  = txData_r;
  assign txValid = txValid_r;
  assign tapeReq = tapeReq_r;
  assign tapeStart = tapeGo_r;
  assign tapeBufRdata = bufRd_r;

  // Pin levels cross into sys_clk through two flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cartMeta_r <= 2'h0;
      cartSync_r <= 2'h0;
      wpMeta_r   <= 2'h0;
      wpSync_r   <= 2'h0;
    end else begin
      cartMeta_r <= cartPresent;
      cartSync_r <= cartMeta_r;
      wpMeta_r   <= writeProtect;
      wpSync_r   <= wpMeta_r;
    end
  end

  // Outgoing packet bytes by kind and position
  always_comb begin
    txByte = 8'h00;
    txLen  = 8'h01;
    unique case (txKind_r)
      PK_CONT: txByte = FLAG_CONT;
      PK_INIT: txByte = FLAG_INIT;
      PK_DATA: begin
        txLen = dataN_r + 8'h04;
        if (txIdx_r == 8'h00) txByte = FLAG_DATA;
        else if (txIdx_r == 8'h01) txByte = dataN_r;
        else if (txIdx_r < dataEnd) txByte = buf_r[bufIdx[6:0]];
        else if (txIdx_r == dataEnd) txByte = txCk_r[7:0];
        else txByte = txCk_r[15:8];
      end
      PK_END: begin
        txLen = END_LEN;
        case (txIdx_r)
          8'h00: txByte = FLAG_CMD;
          8'h01: txByte = PKT_CMD_LEN;
          8'h02: txByte = OP_END;
          8'h03: txByte = result_r;
          8'h04: txByte = {7'h00, unit[0]};
          8'h08: txByte = xfer_r[7:0];
          8'h09: txByte = xfer_r[15:8];
          8'h0B: txByte = summaryOf(result_r);
          8'h0C: txByte = txCk_r[7:0];
          8'h0D: txByte = txCk_r[15:8];
          default: txByte = 8'h00;
        endcase
      end
    endcase
  end

  // Transmit engine; XOFF holds data packets between bytes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txBusy_r  <= 1'b0;
      txValid_r <= 1'b0;
      txData_r  <= 8'h00;
      txIdx_r   <= 8'h00;
      txCk_r    <= 16'h0000;
    end else if (txStart_r) begin
      txBusy_r <= 1'b1;
      txIdx_r  <= 8'h00;
      txCk_r   <= 16'h0000;
    end else if (txBusy_r && (!txValid_r || txReady)) begin
      if (txIdx_r == txLen) begin
        txValid_r <= 1'b0;
        txBusy_r  <= 1'b0;
      end else if (xoff_r && txKind_r == PK_DATA) begin
        txValid_r <= 1'b0;
      end else begin
        txData_r  <= txByte;
        txValid_r <= 1'b1;
        txIdx_r   <= txIdx_r + 8'h01;
        if (txIdx_r + 8'h02 < txLen) txCk_r <= ckAdd(txCk_r, txIdx_r[0], txByte);
      end
    end
  end

  // Flow stop from host during a read; continue releases it
  always_ff @(posedge sys_clk) begin
    if (srst) xoff_r <= 1'b0;
    else if (rxTake && rxData == FLAG_XOFF && state_r == S_RD_TX) xoff_r <= 1'b1;
    else if ((rxTake && rxData == FLAG_CONT) || state_r == S_FINISH) xoff_r <= 1'b0;
  end

  // Transfer buffer: host, tape engine and self-test take turns by state
  always_ff @(posedge sys_clk) begin
    bufRd_r <= buf_r[tapeBufAddr];
    if (state_r == S_WR_CONT || state_r == S_PAD) begin
      for (int i = 0; i < BUF_BYTES; i++) buf_r[i] <= 8'h00;
    end else if (state_r == S_WR_RX && rxTake && rxIdx_r > 8'h01 && rxIdx_r < dataEnd) begin
      buf_r[rxOff[6:0]] <= rxData;
    end else if (state_r == S_DIAG && !diagCnt_r[7]) begin
      buf_r[diagCnt_r[6:0]] <= {1'b0, diagCnt_r[6:0]} ^ DIAG_PATTERN;
    end else if (state_r == S_TAPE && tapeBufWe) begin
      buf_r[tapeBufAddr] <= tapeBufWdata;
    end
  end

  // Request fields and start pulse leave together
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tapeReq_r <= '0;
      tapeGo_r  <= 1'b0;
    end else begin
      tapeGo_r            <= tapeStart_r;
      // Fields load only with the start, so the request stands until the next one
      if (tapeStart_r) begin
        tapeReq_r.op        <= tapeOp_r;
        tapeReq_r.transport <= unit[0];
        tapeReq_r.record    <= record_r;
        tapeReq_r.hiThresh  <= (tapeOp_r == TOP_VERIFY) ||
                               (tapeOp_r == TOP_READ && modf[MOD_HI_BIT]);
        tapeReq_r.noRetry   <= swb[SW_NORETRY_BIT];
      end
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r     <= S_IDLE;
      rxIdx_r     <= 8'h00;
      rxCk_r      <= 16'h0000;
      remain_r    <= 16'h0000;
      xfer_r      <= 16'h0000;
      record_r    <= 11'h000;
      result_r    <= RES_OK;
      dataN_r     <= 8'h00;
      diagCnt_r   <= 8'h00;
      diagFail_r  <= 1'b0;
      ckLoOk_r    <= 1'b0;
      txKind_r    <= PK_CONT;
      txStart_r   <= 1'b0;
      tapeStart_r <= 1'b0;
      tapeOp_r    <= TOP_SEEK;
    end else begin
      txStart_r   <= 1'b0;
      tapeStart_r <= 1'b0;
      unique case (state_r)
        S_IDLE: if (rxTake) begin
          if (rxData == FLAG_CMD) begin
            scratch_r[0] <= rxData;
            rxIdx_r      <= 8'h01;
            rxCk_r       <= ckAdd(16'h0000, 1'b0, rxData);
            state_r      <= S_CMD;
          end else if (rxData == FLAG_INIT) begin
            // Initialize from host: drop state, answer continue
            xfer_r    <= 16'h0000;
            result_r  <= RES_OK;
            txKind_r  <= PK_CONT;
            txStart_r <= 1'b1;
            state_r   <= S_REPLY;
          end
        end
        S_CMD: if (rxTake) begin
          scratch_r[rxIdx_r[6:0]] <= rxData;
          if (rxIdx_r < CMD_CK_LO) rxCk_r <= ckAdd(rxCk_r, rxIdx_r[0], rxData);
          rxIdx_r <= rxIdx_r + 8'h01;
          if (rxIdx_r == CMD_LAST) state_r <= S_EXEC;
        end
        S_EXEC: begin
          xfer_r   <= 16'h0000;
          result_r <= RES_OK;
          remain_r <= cnt;
          record_r <= recFirst;
          state_r  <= S_FINISH;
          if (!cmdCkOk) result_r <= RES_DATA_ERR;
          else if (opc == OP_NOP || opc == OP_GETST || opc == OP_SETST) state_r <= S_FINISH;
          else if (opc == OP_RESET) record_r <= 11'h000;
          else if (opc == OP_DIAG) begin
            diagCnt_r  <= 8'h00;
            diagFail_r <= 1'b0;
            state_r    <= S_DIAG;
          end else if (opc == OP_READ || opc == OP_WRITE || opc == OP_POS) begin
            if (unit > 8'h01) result_r <= RES_NO_UNIT;
            else if (!cartSync_r[unit[0]]) result_r <= RES_NO_CART;
            else if (blk > maxBlk) result_r <= RES_BAD_BLOCK;
            else if (opc == OP_WRITE && wpSync_r[unit[0]]) result_r <= RES_WPROT;
            else if (opc == OP_POS) begin
              tapeOp_r    <= TOP_SEEK;
              tapeStart_r <= 1'b1;
              state_r     <= S_TAPE;
            end else if (cnt == 16'h0000) state_r <= S_FINISH;
            else if (opc == OP_READ) begin
              tapeOp_r    <= TOP_READ;
              tapeStart_r <= 1'b1;
              state_r     <= S_TAPE;
            end else begin
              txKind_r  <= PK_CONT;
              txStart_r <= 1'b1;
              state_r   <= S_WR_CONT;
            end
          end else result_r <= RES_BAD_OP;
        end
        S_TAPE: if (tapeDone) begin
          if (tapeResult[7]) begin
            result_r <= tapeResult;
            state_r  <= S_FINISH;
          end else begin
            if (tapeResult == RES_RETRY) result_r <= RES_RETRY;
            if (tapeOp_r == TOP_SEEK) state_r <= S_FINISH;
            else if (tapeOp_r == TOP_READ) begin
              dataN_r   <= (remain_r > {8'h00, REC_BYTES}) ? REC_BYTES : remain_r[7:0];
              txKind_r  <= PK_DATA;
              txStart_r <= 1'b1;
              state_r   <= S_RD_TX;
            end else if (tapeOp_r == TOP_WRITE && modf[MOD_HI_BIT]) begin
              tapeOp_r    <= TOP_VERIFY;
              tapeStart_r <= 1'b1;
            end else if (remain_r != 16'h0000) begin
              record_r  <= recNext;
              txKind_r  <= PK_CONT;
              txStart_r <= 1'b1;
              state_r   <= S_WR_CONT;
            end else if (!special && recNext[1:0] != 2'b00) begin
              record_r <= recNext;
              state_r  <= S_PAD;
            end else state_r <= S_FINISH;
          end
        end
        S_RD_TX: if (!txWait) begin
          xfer_r   <= xfer_r + {8'h00, dataN_r};
          remain_r <= remain_r - {8'h00, dataN_r};
          record_r <= recNext;
          if (remain_r == {8'h00, dataN_r}) state_r <= S_FINISH;
          else begin
            tapeOp_r    <= TOP_READ;
            tapeStart_r <= 1'b1;
            state_r     <= S_TAPE;
          end
        end
        S_WR_CONT: if (!txWait) begin
          rxIdx_r <= 8'h00;
          rxCk_r  <= 16'h0000;
          dataN_r <= REC_BYTES;  // Stale count must not hit the flag or count byte
          state_r <= S_WR_RX;
        end
        S_WR_RX: if (rxTake) begin
          rxIdx_r <= rxIdx_r + 8'h01;
          if (rxIdx_r < dataEnd || rxIdx_r == 8'h01) rxCk_r <= ckAdd(rxCk_r, rxIdx_r[0], rxData);
          if (rxIdx_r == 8'h00 && rxData != FLAG_DATA) begin
            result_r <= RES_DATA_ERR;
            state_r  <= S_FINISH;
          end else if (rxIdx_r == 8'h01) begin
            dataN_r <= rxData;
            if (rxData > REC_BYTES || rxData == 8'h00) begin
              result_r <= RES_DATA_ERR;
              state_r  <= S_FINISH;
            end
          end else if (rxIdx_r == dataEnd) ckLoOk_r <= rxData == rxCk_r[7:0];
          else if (rxIdx_r == dataEnd + 8'h01) begin
            if (ckLoOk_r && rxData == rxCk_r[15:8]) begin
              xfer_r   <= xfer_r + ((remain_r > {8'h00, dataN_r}) ? {8'h00, dataN_r} : remain_r);
              remain_r <= (remain_r > {8'h00, dataN_r}) ? remain_r - {8'h00, dataN_r} : 16'h0000;
              tapeOp_r    <= TOP_WRITE;
              tapeStart_r <= 1'b1;
              state_r     <= S_TAPE;
            end else begin
              result_r <= RES_DATA_ERR;
              state_r  <= S_FINISH;
            end
          end
        end
        S_PAD: begin
          tapeOp_r    <= TOP_WRITE;
          tapeStart_r <= 1'b1;
          state_r     <= S_TAPE;
        end
        S_DIAG: begin
          // Pattern write pass, then a compare pass over the buffer
          diagCnt_r <= diagCnt_r + 8'h01;
          if (diagCnt_r[7] && buf_r[diagCnt_r[6:0]] != ({1'b0, diagCnt_r[6:0]} ^ DIAG_PATTERN))
            diagFail_r <= 1'b1;
          if (diagCnt_r == 8'hFF) begin
            result_r <= diagFail_r ? RES_SELFTEST : RES_OK;
            state_r  <= S_FINISH;
          end
        end
        S_FINISH: begin
          txKind_r  <= PK_END;
          txStart_r <= 1'b1;
          state_r   <= S_REPLY;
        end
        S_REPLY: if (!txWait) state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Avalon slave: one wait state, then the answer stands for one cycle
  assign avsWaitRequest = (avsRead || avsWrite) && !ack_r;
  assign avsReadData    = rdData_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_r    <= 1'b0;
      rdData_r <= 32'h0000_0000;
      ctrl_r   <= CTRL_RESET;
    end else begin
      ack_r <= (avsRead || avsWrite) && !ack_r;
      if (avsRead && !ack_r) begin
        unique case (avsAddress)
          REG_CTRL:   rdData_r <= ctrl_r;
          REG_STATUS: rdData_r <= {23'h000000, xoff_r, wpSync_r, cartSync_r, state_r};
          REG_RESULT: rdData_r <= {16'h0000, summaryOf(result_r), result_r};
          REG_COUNT:  rdData_r <= {16'h0000, xfer_r};
          default:    rdData_r <= 32'h0000_0000;
        endcase
      end
      if (avsWrite && ack_r && avsAddress == REG_CTRL) ctrl_r <= {31'h0, avsWriteData[0]};
    end
  end
endmodule : tape_packet_command_controller

// ==== tape_packet_command_controller_tb_top.sv ====
// Purpose: Self-checking bench for the tape packet command controller
// Assumes: Bench acts as host link and register master
// Notes: Expected bytes queued by the driver, compared by the tx monitor
`timescale 1ns/1ps
module tape_packet_command_controller_tb_top
  import tape_pkt_pkg::*;
;
  logic sys_clk = 0, srst = 1, avsRead = 0, avsWrite = 0, rxValid = 0, txReady = 0;
  logic [3:0] avsAddress = '0;
  logic [31:0] avsWriteData = '0, avsReadData, q;
  logic [7:0] rxData = '0, txData, tapeResult, tapeBufWdata, tapeBufRdata;
  logic avsWaitRequest, rxReady, txValid, tapeStart, tapeDone, tapeBufWe;
  logic [6:0] tapeBufAddr;
  logic [10:0] expRec;
  tapeReq_s tapeReq;
  logic [7:0] expq[$];
  logic [31:0] rs = 32'hF617;
  int failures = 0, n_checks = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  tape_packet_command_controller u_dut (.sys_clk(sys_clk), .srst(srst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .tapeReq(tapeReq), .tapeStart(tapeStart),
    .tapeDone(tapeDone), .tapeResult(tapeResult), .tapeBufAddr(tapeBufAddr),
    .tapeBufWe(tapeBufWe), .tapeBufWdata(tapeBufWdata), .tapeBufRdata(tapeBufRdata),
    .cartPresent(2'b01), .writeProtect(2'b00));
  tape_engine_model u_tape (.sys_clk(sys_clk), .tapeReq(tapeReq), .tapeStart(tapeStart),
    .tapeDone(tapeDone), .tapeResult(tapeResult), .tapeBufAddr(tapeBufAddr),
    .tapeBufWe(tapeBufWe), .tapeBufWdata(tapeBufWdata));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13); rs = rs ^ (rs >> 17); rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // End-around carry sum, even index is the low byte
  function automatic logic [15:0] ck(input logic [7:0] b[$]);
    logic [16:0] s;
    s = '0;
    foreach (b[i]) s = {1'b0, s[15:0]} + s[16] + (i[0] ? {b[i], 8'h00} : {8'h00, b[i]});
    s = s[15:0] + s[16];
    return s[15:0];
  endfunction : ck
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin failures++; $display("ERROR %0t %s", $time, m); end
  endtask : check
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a; avsWriteData <= d; avsRead <= !wr; avsWrite <= wr;
    do @(posedge sys_clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData; avsRead <= 1'b0; avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask : avs
  task automatic putb(input logic [7:0] b);
    rxValid <= 1'b1; rxData <= b;
    do @(posedge sys_clk); while (rxReady !== 1'b1);
  endtask : putb
  // One command packet, expected reply queued first
  task automatic cmd(input logic [7:0] op, md, un, input logic [15:0] cnt, blk,
                     input logic [7:0] code, sm);
    logic [7:0] c[$]; logic [7:0] e[$]; logic [7:0] d[$]; logic [15:0] k, xf;
    xf = (op == OP_READ || op == OP_WRITE) ? cnt : 16'h0000;
    expRec = md[7] ? blk[10:0] : {blk[8:0], 2'b00};
    d = '{FLAG_DATA, cnt[7:0]};
    for (int i = 0; i < cnt; i++) d.push_back(expRec[7:0] + i[7:0]);
    k = ck(d); d.push_back(k[7:0]); d.push_back(k[15:8]);
    e = '{FLAG_CMD, PKT_CMD_LEN, OP_END, code, un, 8'h00, 8'h00, 8'h00,
          xf[7:0], xf[15:8], 8'h00, sm};
    k = ck(e); e.push_back(k[7:0]); e.push_back(k[15:8]);
    c = '{FLAG_CMD, PKT_CMD_LEN, op, md, un, 8'h00, 8'h00, 8'h00,
          cnt[7:0], cnt[15:8], blk[7:0], blk[15:8]};
    k = ck(c); c.push_back(k[7:0]); c.push_back(k[15:8]);
    if (op == OP_READ) foreach (d[i]) expq.push_back(d[i]);
    if (op == OP_WRITE) expq.push_back(FLAG_CONT);
    foreach (e[i]) expq.push_back(e[i]);
    foreach (c[i]) putb(c[i]);
    rxValid <= 1'b0;
    if (op == OP_WRITE) begin
      while (expq.size() > 14) @(posedge sys_clk);
      foreach (d[i]) putb(d[i]);
      rxValid <= 1'b0;
    end
    while (expq.size() != 0) @(posedge sys_clk);
    $display("test op %h unit %h code %h done", op, un, code);
  endtask : cmd
  // Host link monitor and timeout
  always @(posedge sys_clk) begin
    txReady <= rnd() % 4 != 0;
    if (++cyc > 40000) begin failures++; summarize(); end
    if (!srst && tapeStart === 1'b1) check(tapeReq.record === expRec, "record");
    if (!srst && txValid === 1'b1 && txReady === 1'b1) begin
      if (expq.size() == 0) check(1'b0, "unexpected tx byte");
      else check(txData === expq.pop_front(), "tx byte mismatch");
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    avs(1'b0, REG_CTRL, 0); check(q === 32'h0000_0001, "ctrl reset");
    avs(1'b0, 4'h2, 0); check(q === 32'h0000_0000, "unmapped read");
    avs(1'b1, REG_CTRL, rnd() & 32'hFFFF_FFFE); check(rxReady === 1'b0, "rx gate");
    avs(1'b1, REG_CTRL, 32'h0000_0001); check(rxReady === 1'b1, "rx open");
    cmd(OP_NOP, 0, 0, 0, 0, RES_OK, 0);
    cmd(OP_RESET, 0, 0, 0, 0, RES_OK, 0);
    cmd(OP_GETST, 0, 0, 0, 0, RES_OK, 0);
    cmd(OP_SETST, 0, 0, 0, 0, RES_OK, 0);
    cmd(8'h06, 0, 0, 0, 0, RES_BAD_OP, 8'h90);
    avs(1'b0, REG_RESULT, 0); check(q[15:0] === 16'h90D0, "result reg");
    cmd(OP_POS, 0, 0, 0, 3, RES_OK, 0);
    cmd(OP_POS, 8'h80, 0, 0, 1000, RES_OK, 0);
    cmd(OP_POS, 0, 1, 0, 3, RES_NO_CART, 8'hA0);
    cmd(OP_POS, 0, 0, 0, 600, RES_BAD_BLOCK, 8'h90);
    cmd(OP_DIAG, 0, 0, 0, 0, RES_OK, 0);
    cmd(OP_READ, 8'h01, 0, 5, 1, RES_OK, 0);
    cmd(OP_WRITE, 8'h80, 0, 3, 7, RES_OK, 0);
    summarize();
  end
endmodule : tape_packet_command_controller_tb_top

// ==== tape_pkt_pkg.sv ====
// Purpose: Constants, types and helpers for the tape packet command controller
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes: Packet flag, opcode and result values are the octal protocol values in hex
// Contract
// - RAM split: 128 scratch, 128 transfer buffer
// - Six packet types carry all traffic
// - Read: seek, fill buffer, send, repeat
// - End packet after byte count is met
// - Write: receive record, write, request more
// - Command packet fourteen bytes, flag, count
// - No-op and status opcodes answer end
// - Reset opcode reinitializes then answers end
// - Read; modifier bit 0 raises threshold
// - Write zero-fills rest of final block
// - Write-verify rereads each record raised threshold
// - Position moves tape, then answers end
// - Diagnose runs self-test, then answers end
// - Modifier bit 7: 2048 blocks of 128
// - Byte 4 selects transport 0 or 1
// - Switch bit 4 suppresses read retries
// - Command fields: count, block, checksum
// - End packet: command flag, count, end opcode
// - End byte 3 gives outcome code
// - Specific failure codes for each fault
// - End bytes 4-9: transport, zeros, count
// - End byte 11 holds error summary bits
// - Data packet: flag, count, data, checksum
// - Sixteen-bit checksum per 128-byte record
// - Continue packet is one flag byte
package tape_pkt_pkg;
  // Packet flags, lengths and command byte indices
  localparam logic [7:0] FLAG_DATA = 8'h01;
  localparam logic [7:0] FLAG_CMD  = 8'h02;
  localparam logic [7:0] FLAG_INIT = 8'h04;
  localparam logic [7:0] FLAG_BOOT = 8'h08;
  localparam logic [7:0] FLAG_CONT = 8'h10;
  localparam logic [7:0] FLAG_XOFF = 8'h13;
  localparam logic [7:0] PKT_CMD_LEN = 8'h0A;
  localparam logic [7:0] CMD_LAST    = 8'h0D;
  localparam logic [7:0] CMD_CK_LO   = 8'h0C;
  localparam logic [7:0] END_LEN     = 8'h0E;
  // Command byte positions
  localparam int CB_OP = 2, CB_MOD = 3, CB_UNIT = 4, CB_SW = 5;
  localparam int CB_CNT = 8, CB_BLK = 10, CB_CK = 12;
  localparam int MOD_HI_BIT = 0, MOD_SPECIAL_BIT = 7, SW_NORETRY_BIT = 4;
  // Opcodes
  localparam logic [7:0] OP_NOP = 8'h00, OP_RESET = 8'h01, OP_READ = 8'h02;
  localparam logic [7:0] OP_WRITE = 8'h03, OP_POS = 8'h05, OP_DIAG = 8'h07;
  localparam logic [7:0] OP_GETST = 8'h08, OP_SETST = 8'h09, OP_END = 8'h40;
  // Outcome codes
  localparam logic [7:0] RES_OK = 8'h00, RES_RETRY = 8'h01, RES_SELFTEST = 8'hFF;
  localparam logic [7:0] RES_PARTIAL = 8'hFE, RES_NO_UNIT = 8'hF8, RES_NO_CART = 8'hF7;
  localparam logic [7:0] RES_WPROT = 8'hF5, RES_DATA_ERR = 8'hEF, RES_SEEK = 8'hE0;
  localparam logic [7:0] RES_MOTOR = 8'hDF, RES_BAD_OP = 8'hD0, RES_BAD_BLOCK = 8'hC9;
  // Storage and addressing
  localparam int SCRATCH_BYTES = 128, BUF_BYTES = 128;
  localparam logic [7:0]  REC_BYTES    = 8'h80;
  localparam logic [15:0] MAX_BLK_NORM = 16'h01FF;
  localparam logic [15:0] MAX_BLK_SPEC = 16'h07FF;
  localparam logic [7:0]  DIAG_PATTERN = 8'hA5;
  // Register map
  localparam logic [3:0]  REG_CTRL = 4'h0, REG_STATUS = 4'h4, REG_RESULT = 4'h8;
  localparam logic [3:0]  REG_COUNT = 4'hC;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {TOP_SEEK = 2'b00, TOP_READ = 2'b01, TOP_WRITE = 2'b10,
                            TOP_VERIFY = 2'b11} tapeOp_e;
  typedef enum logic [1:0] {PK_CONT = 2'b00, PK_INIT = 2'b01, PK_DATA = 2'b10,
                            PK_END = 2'b11} pktKind_e;
  typedef enum logic [3:0] {S_IDLE = 4'h0, S_CMD = 4'h1, S_EXEC = 4'h2, S_TAPE = 4'h3,
                            S_RD_TX = 4'h4, S_WR_CONT = 4'h5, S_WR_RX = 4'h6,
                            S_PAD = 4'h7, S_DIAG = 4'h8, S_FINISH = 4'h9,
                            S_REPLY = 4'hA} state_e;
  typedef struct packed {
    tapeOp_e     op;
    logic        transport;
    logic [10:0] record;
    logic        hiThresh;
    logic        noRetry;
  } tapeReq_s;

  // End-around carry sum; even positions are the low byte
  function automatic logic [15:0] ckAdd(input logic [15:0] ck, input logic hi,
                                        input logic [7:0] b);
    logic [16:0] s;
    s = {1'b0, ck} + {1'b0, (hi ? {b, 8'h00} : {8'h00, b})};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ckAdd

  // Error summary byte from an outcome code
  function automatic logic [7:0] summaryOf(input logic [7:0] c);
    logic [2:0] e;
    e = 3'b000;
    e[0] = (c == RES_NO_UNIT) || (c == RES_BAD_OP) || (c == RES_BAD_BLOCK) || (c == RES_WPROT);
    e[1] = (c == RES_NO_CART) || (c == RES_SEEK) || (c == RES_MOTOR) || (c == RES_PARTIAL);
    e[2] = (c == RES_DATA_ERR) || (c == RES_SELFTEST);
    return {|e, e, 4'h0};
  endfunction : summaryOf
endpackage : tape_pkt_pkg

// ==== tape_pkt_properties.sv ====
// Purpose: Port-level checks of the tape packet command controller
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only top-level ports; bound below
`timescale 1ns/1ps
module tape_pkt_properties
  import tape_pkt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        rxReady,
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  input tapeReq_s         tapeReq,
  input wire logic        tapeStart
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Access phases
  sequence accNew; (avsRead || avsWrite) && !$past(avsRead || avsWrite); endsequence
  sequence accWait; (avsRead || avsWrite) && avsWaitRequest; endsequence
  wait_first_a: assert property (accNew |-> avsWaitRequest) else $error("no wait state");
  one_wait_a: assert property (accWait |=> !avsWaitRequest) else $error("wait too long");
  unmapped_zero_a: assert property (avsRead && !avsWaitRequest && avsAddress[1:0] != 2'b00
    |-> avsReadData == 32'h0000_0000) else $error("unmapped read not zero");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte dropped");
  start_pulse_a: assert property (tapeStart |=> !tapeStart) else $error("start too long");
  req_stands_a: assert property (!tapeStart |-> $stable(tapeReq)) else $error("req moved");
  busy_block_a: assert property (tapeStart |=> !rxReady) else $error("rx open in tape op");
  reset_quiet_a: assert property ($past(srst) |-> !txValid && !tapeStart)
    else $error("active after reset");
endmodule : tape_pkt_properties

bind tape_packet_command_controller tape_pkt_properties u_props (
  .sys_clk(sys_clk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
  .tapeReq(tapeReq), .tapeStart(tapeStart));
